// ===== design/tap_params.svh
// constants for the boundary-scan test access port
// assumes inclusion by tap_pkg, the top module and the bench files
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH
// ----------------------------------------
// instruction register
// ----------------------------------------
`define IR_W        6
`define IR_CAPTURE  6'h01
`define OP_EXTEST   6'h00
`define OP_SAMPLE   6'h01
`define OP_IDCODE   6'h02
`define OP_BYPASS   6'h3f
// ----------------------------------------
// data registers
// ----------------------------------------
`define BSR_PINS    4
`define BSR_W       12
// arbitrary identity value, bit 0 set as usual
`define IDCODE_VAL  32'h0000_0001
`define ID_W        32
`endif

// ===== design/tap_pkg.sv
// types shared by the test access port
// assumes tap_params.svh is on the include path
package tap_pkg;
`include "tap_params.svh"
  // ----------------------------------------
  // controller states, one-hot
  // ----------------------------------------
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } tap_state_t;
  // pad data and enables travel together
  typedef struct packed {
    logic [`BSR_PINS-1:0] dat;
    logic [`BSR_PINS-1:0] oe;
  } pad_drive_t;
endpackage

// ===== design/tap_port.sv
// boundary-scan test access port with a small scan cell chain
// assumes TCK is a free clock from the tester; CLK_SYS drives pads
// Function
// - low test reset forces Test-Logic-Reset at once, without clock
// - mode select and serial input sampled only on rising test clock
// - serial output changes on falling test clock edge
// - serial output driven only in Shift-DR and Shift-IR, else released
// - controller advances every rising edge, next state from mode select only
// - five ones on mode select reach Test-Logic-Reset from any state
// - serial input routed to chain, instruction, identity or bypass
// - sixteen-state controller, six-bit instruction, five test pins
// - new instruction applied only at Update-IR (IDCODE in Test-Logic-Reset); old one holds meanwhile
// - bypass, chain and identity in parallel, chosen by instruction
// - chain output latches reach pads after a system-clock resync when EXTEST updates
`include "tap_params.svh"

module tap_port
  import tap_pkg::*;
(
  input  wire logic       CLK_SYS,  // system clock
  input  wire logic       RST_N,    // system reset, low
  input  wire logic       TCK,      // test clock
  input  wire logic       TRST_N,   // test reset, low
  input  wire logic       TMS,      // mode select
  input  wire logic       TDI,      // serial data in
  output logic            TDO,      // serial data out
  output logic            TDO_OE,   // high while TDO driven
  input  wire tap_pkg::pad_drive_t CORE_DRV, // core pad values
  input  wire logic [`BSR_PINS-1:0] PIN_IN, // pad levels seen
  output tap_pkg::pad_drive_t      PAD_DRV,  // values to pads
  output logic            EXTEST_ACT // pads under test control
);
  import tap_pkg::*;

  // ----------------------------------------
  // decoding helpers
  // ----------------------------------------
  // standard sixteen-state transition table
  function automatic tap_state_t tap_next(input tap_state_t s,
                                          input logic m);
    case (s)
      ST_TLR:    tap_next = m ? ST_TLR    : ST_RTI;
      ST_RTI:    tap_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  tap_next = m ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_next = m ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  tap_next = m ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
      default:   tap_next = ST_TLR;
    endcase
  endfunction

  // chain selected by test instructions
  function automatic logic sel_chain(input logic [`IR_W-1:0] ir);
    sel_chain = (ir == `OP_EXTEST) || (ir == `OP_SAMPLE);
  endfunction

  // identity register chosen only by its own code
  function automatic logic sel_id(input logic [`IR_W-1:0] ir);
    sel_id = (ir == `OP_IDCODE);
  endfunction

  // ----------------------------------------
  // test clock domain: capture synchroniser
  // ----------------------------------------
  logic [`BSR_W-1:0] cap_s1_r;
  logic [`BSR_W-1:0] cap_s2_r;

  // pads and core values come from other clocks
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      cap_s1_r <= '0;
      cap_s2_r <= '0;
    end else begin
      cap_s1_r <= {PIN_IN, CORE_DRV.dat, CORE_DRV.oe};
      cap_s2_r <= cap_s1_r;
    end
  end

  // ----------------------------------------
  // test clock domain: controller and shift registers
  // ----------------------------------------
  // rising-edge controller state and the shift registers
  tap_state_t           state_r;
  tap_state_t           state_nxt;
  logic [`IR_W-1:0]     ir_sh_r;
  logic [`IR_W-1:0]     ir_sh_nxt;
  logic [`BSR_W-1:0]    bsr_sh_r;
  logic [`BSR_W-1:0]    bsr_sh_nxt;
  logic [`ID_W-1:0]     id_sh_r;
  logic [`ID_W-1:0]     id_sh_nxt;
  logic                 byp_r;
  logic                 byp_nxt;
  logic [`IR_W-1:0]     ir_r;

  // next state, capture and shift on the rising edge
  always_comb begin
    state_nxt  = tap_next(state_r, TMS);
    ir_sh_nxt  = ir_sh_r;
    bsr_sh_nxt = bsr_sh_r;
    id_sh_nxt  = id_sh_r;
    byp_nxt    = byp_r;
    case (state_r)
      ST_CAP_IR: ir_sh_nxt = `IR_CAPTURE;
      ST_SH_IR:  ir_sh_nxt = {TDI, ir_sh_r[`IR_W-1:1]};
      ST_CAP_DR: begin
        if (sel_chain(ir_r)) begin
          bsr_sh_nxt = cap_s2_r;
        end else if (sel_id(ir_r)) begin
          id_sh_nxt = `IDCODE_VAL;
        end else begin
          byp_nxt = 1'b0;
        end
      end
      ST_SH_DR: begin
        if (sel_chain(ir_r)) begin
          bsr_sh_nxt = {TDI, bsr_sh_r[`BSR_W-1:1]};
        end else if (sel_id(ir_r)) begin
          id_sh_nxt = {TDI, id_sh_r[`ID_W-1:1]};
        end else begin
          byp_nxt = TDI;
        end
      end
      default: begin
        ir_sh_nxt = ir_sh_r;
      end
    endcase
  end

  // only rising-edge sampling of mode select and data
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      state_r  <= ST_TLR;
      ir_sh_r  <= '0;
      bsr_sh_r <= '0;
      id_sh_r  <= '0;
      byp_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      ir_sh_r  <= ir_sh_nxt;
      bsr_sh_r <= bsr_sh_nxt;
      id_sh_r  <= id_sh_nxt;
      byp_r    <= byp_nxt;
    end
  end

  // ----------------------------------------
  // test clock domain: falling-edge updates and output
  // ----------------------------------------
  logic [`IR_W-1:0] ir_nxt;
  pad_drive_t       upd_r;
  pad_drive_t       upd_nxt;
  logic             upd_tog_r;
  logic             upd_tog_nxt;
  logic             tdo_r;
  logic             tdo_nxt;
  logic             tdo_oe_r;
  logic             tdo_oe_nxt;
  logic             ext_r;
  logic             ext_nxt;
  logic             shifting;

  // enable follows the two shift states only
  assign shifting = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);

  // updates wait for the falling edge so the shift path is settled
  always_comb begin
    ir_nxt      = ir_r;
    upd_nxt     = upd_r;
    upd_tog_nxt = upd_tog_r;
    if (state_r == ST_TLR) begin
      ir_nxt = `OP_IDCODE;
    end else if (state_r == ST_UPD_IR) begin
      ir_nxt      = ir_sh_r;
      upd_tog_nxt = ~upd_tog_r;
    end else if (state_r == ST_UPD_DR && sel_chain(ir_r)) begin
      upd_nxt     = bsr_sh_r[2*`BSR_PINS-1:0];
      upd_tog_nxt = ~upd_tog_r;
    end
    if (state_r == ST_SH_IR) begin
      tdo_nxt = ir_sh_r[0];
    end else if (sel_chain(ir_r)) begin
      tdo_nxt = bsr_sh_r[0];
    end else if (sel_id(ir_r)) begin
      tdo_nxt = id_sh_r[0];
    end else begin
      tdo_nxt = byp_r;
    end
    tdo_oe_nxt = shifting;
    // one clean decoded bit crosses, never the six-bit word
    ext_nxt    = (ir_nxt == `OP_EXTEST);
  end

  // falling-edge bank; tester samples it at the next rise
  always_ff @(negedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      ir_r      <= `OP_IDCODE;
      upd_r     <= '0;
      upd_tog_r <= 1'b0;
      tdo_r     <= 1'b0;
      tdo_oe_r  <= 1'b0;
      ext_r     <= 1'b0;
    end else begin
      ir_r      <= ir_nxt;
      upd_r     <= upd_nxt;
      upd_tog_r <= upd_tog_nxt;
      tdo_r     <= tdo_nxt;
      tdo_oe_r  <= tdo_oe_nxt;
      ext_r     <= ext_nxt;
    end
  end

  // pin side of the serial output
  assign TDO    = tdo_r;
  assign TDO_OE = tdo_oe_r;

  // ----------------------------------------
  // system clock domain: reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_s2_r;

  // assertion is immediate, release waits two system clocks
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // system clock domain: crossing and pad mux
  // ----------------------------------------
  logic       ext_s1_r;
  logic       ext_s2_r;
  logic       tog_s1_r;
  logic       tog_s2_r;
  logic       tog_s3_r;
  pad_drive_t held_r;
  pad_drive_t held_nxt;
  pad_drive_t pad_r;
  pad_drive_t pad_nxt;
  logic       ext_lvl;

  // registered test-clock level, steady between updates
  assign ext_lvl = ext_r;

  // two-stage resync; a third toggle stage finds the edge
  always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_lvl;
      ext_s2_r <= ext_s1_r;
      tog_s1_r <= upd_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
    end
  end

  // latches are copied only after the toggle settles; limitation:
  // two updates closer than a few system clocks merge into one
  always_comb begin
    held_nxt = held_r;
    if (tog_s2_r != tog_s3_r) begin
      held_nxt = upd_r;
    end
    pad_nxt = ext_s2_r ? held_nxt : CORE_DRV;
  end

  // pads come from flip-flops so they never glitch
  always_ff @(posedge CLK_SYS or negedge rst_s2_r) begin
    if (!rst_s2_r) begin
      held_r <= '0;
      pad_r  <= '0;
    end else begin
      held_r <= held_nxt;
      pad_r  <= pad_nxt;
    end
  end

  // outputs straight from the registers
  assign PAD_DRV    = pad_r;
  assign EXTEST_ACT = ext_s2_r;
endmodule

// ===== tb/tap_port_monitor.sv
// checker on the test access port pins and pads
// assumes tap_pkg is compiled first; bound to tap_port below
`include "tap_params.svh"
module tap_port_monitor
  import tap_pkg::*;
(
  input wire logic                CLK_SYS,   // sys clk
  input wire logic                RST_N,     // sys rst
  input wire logic                TCK,       // test clk
  input wire logic                TRST_N,    // test rst
  input wire logic                TMS,       // mode
  input wire logic                TDO,       // data out
  input wire logic                TDO_OE,    // out en
  input wire tap_pkg::pad_drive_t CORE_DRV,  // core
  input wire tap_pkg::pad_drive_t PAD_DRV,   // pads
  input wire logic                EXTEST_ACT // test mode
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = `IDCODE_VAL;
  localparam logic [5:0] CAP = `IR_CAPTURE;
  logic [1:0] rise_r; // pins seen at last rise
  // snapshot at each rise; test reset clears it, so no stale history
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) rise_r <= 2'b00;
    else rise_r <= {TDO, TDO_OE};
  end
  sequence ones5; TMS [*5]; endsequence
  sequence to_dr; !TMS ##1 TMS ##1 !TMS [*2]; endsequence
  sequence to_ir; !TMS ##1 TMS [*2] ##1 !TMS [*2]; endsequence
  a_tdo_on_fall: assert property (@(negedge TCK) disable iff (!TRST_N)
    {TDO, TDO_OE} == rise_r) else $error("out moved on rise");
  a_oe_enter: assert property (@(posedge TCK) disable iff (!TRST_N)
    TDO_OE && !rise_r[0] |-> !$past(TMS)) else $error("drive without shift");
  a_oe_leave: assert property (@(posedge TCK) disable iff (!TRST_N)
    !TDO_OE && rise_r[0] |-> $past(TMS)) else $error("left shift on zero");
  a_ones_to_id: assert property (@(posedge TCK) disable iff (!TRST_N)
    ones5 ##1 to_dr |=> TDO_OE && TDO == ID[0]) else $error("ones gave no reset");
  a_ir_capture: assert property (@(posedge TCK) disable iff (!TRST_N)
    ones5 ##1 to_ir |=> TDO_OE && TDO == CAP[0]) else $error("bad ir capture");
  a_trst_async: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !TRST_N |-> !TDO_OE && !TDO) else $error("test reset ignored");
  a_pad_follow: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $past(RST_N, 3) && !$past(EXTEST_ACT) |-> PAD_DRV == $past(CORE_DRV)) else $error("pads not core");
  a_pad_held: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    EXTEST_ACT [*4] |=> $stable(PAD_DRV)) else $error("held pads moved");
endmodule
bind tap_port tap_port_monitor mon (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .TCK(TCK), .TRST_N(TRST_N), .TMS(TMS),
  .TDO(TDO), .TDO_OE(TDO_OE), .CORE_DRV(CORE_DRV), .PAD_DRV(PAD_DRV), .EXTEST_ACT(EXTEST_ACT));

// ===== tb/tap_port_tb.sv
// self-checking bench for the test access port
// assumes tap_tester on the link and the bound checker
`include "tap_params.svh"
module tap_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tap_pkg::*;
`define CK(NM, E, S) begin total_checks++; if ((S) !== (E)) begin failures++; \
  $display("[ERR] %s exp %h got %h", NM, E, S); end end
  logic CLK_SYS = 0, RST_N = 0, TRST_N = 0, TCK, TMS, TDI, TDO, TDO_OE, EXTEST_ACT;
  pad_drive_t CORE_DRV, PAD_DRV, pre;
  logic [`BSR_PINS-1:0] PIN_IN;
  logic [31:0] got, din;
  int failures = 0, total_checks = 0;
  logic [5:0] byp [3] = '{`OP_BYPASS, 6'h15, 6'h2a}; // unused codes fall to bypass
  always #2.5 CLK_SYS = ~CLK_SYS;
  tap_port DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .TCK(TCK), .TRST_N(TRST_N), .TMS(TMS), .TDI(TDI), .TDO(TDO),
    .TDO_OE(TDO_OE), .CORE_DRV(CORE_DRV), .PIN_IN(PIN_IN), .PAD_DRV(PAD_DRV), .EXTEST_ACT(EXTEST_ACT));
  tap_tester tt (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE));
  function automatic logic [11:0] chain_exp(logic [3:0] p, pad_drive_t c);
    return {p, c.dat, c.oe};
  endfunction
  // report, shared with the hang guard
  task automatic give_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic set_ir(logic [5:0] op);
    tt.shift(1, {26'h0, op}, 6, 1, got);
    `CK("ir capture", `IR_CAPTURE, got[5:0])
  endtask
  task automatic id_scan(string nm);
    tt.shift(0, 0, 32, 1, got);
    `CK(nm, `IDCODE_VAL, got)
  endtask
  // fresh pads must pass straight through, checked three cycles later
  task automatic new_pads();
    @(posedge CLK_SYS);
    CORE_DRV <= pad_drive_t'(8'($urandom));
    PIN_IN <= 4'($urandom);
    repeat (3) @(posedge CLK_SYS);
    `CK("follow", CORE_DRV, PAD_DRV)
  endtask
  // hang guard, far beyond the expected run
  initial begin
    #400us;
    failures++;
    give_verdict();
  end
  initial begin
    CORE_DRV = '0;
    PIN_IN = '0;
    void'($urandom(32'hee5e0c8a));
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1;
    TRST_N <= 1;
    tt.home();
    set_ir(`OP_IDCODE);
    id_scan("id");
    for (int r = 0; r < 4; r++) begin
      new_pads();
      set_ir(`OP_SAMPLE);
      pre = pad_drive_t'(8'($urandom));
      tt.shift(0, {24'h0, pre}, 12, 1, got);
      `CK("chain", chain_exp(PIN_IN, CORE_DRV), got[11:0])
      tt.shift(1, {26'h0, `OP_EXTEST}, 6, 0, got);
      @(posedge CLK_SYS) CORE_DRV <= pad_drive_t'(~pre);
      repeat (8) @(posedge CLK_SYS);
      `CK("early", 1'b0, EXTEST_ACT)
      tt.step(1, 0);
      tt.step(0, 0);
      repeat (8) @(posedge CLK_SYS);
      `CK("extest", 1'b1, EXTEST_ACT)
      `CK("held", pre, PAD_DRV)
      set_ir(byp[r % 3]);
      din = $urandom;
      tt.shift(0, din, 8, 1, got);
      `CK("bypass", {din[6:0], 1'b0}, got[7:0])
    end
    // five ones out of a live data shift
    tt.step(1, 0);
    tt.step(0, 0);
    tt.step(0, 0);
    tt.step(0, 1);
    `CK("drive", 1'b1, TDO_OE)
    tt.home();
    `CK("release", 1'b0, TDO_OE)
    id_scan("ones");
    // test reset with the clock stopped mid shift
    set_ir(`OP_BYPASS);
    tt.step(1, 0);
    tt.step(0, 0);
    tt.step(0, 0);
    @(posedge CLK_SYS) TRST_N <= 0;
    @(posedge CLK_SYS) TRST_N <= 1;
    `CK("trst", 1'b0, TDO_OE)
    tt.home();
    id_scan("trst id");
    give_verdict();
  end
endmodule

// ===== tb/tap_tester.sv
// test controller model driving the link pins
// assumes the bench calls its tasks; TCK rests low between scans
module tap_tester (
  output logic      TCK,   // test clk
  output logic      TMS,   // mode
  output logic      TDI,   // data in
  input  wire logic TDO,   // data out
  input  wire logic TDO_OE // out en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic seen; // bit taken at last rise
  initial {TCK, TMS, TDI} = 3'b011;
  // pins settle while low, the rise takes them
  task automatic step(input logic m, input logic d);
    TMS = m;
    TDI = d;
    #32 TCK = 1;
    seen = TDO_OE ? TDO : 1'bz;
    #32 TCK = 0;
  endtask
  // five ones reach reset, one zero to idle
  task automatic home();
    repeat (5) step(1, 0);
    step(0, 0);
  endtask
  // scan from idle, lsb first; without upd it stops in exit
  task automatic shift(input bit ir, input logic [31:0] d, input int n, input bit upd, output logic [31:0] q);
    q = '0;
    step(1, 0);
    if (ir) step(1, 0);
    step(0, 0);
    step(0, 0);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i]);
      q[i] = seen;
    end
    if (upd) begin
      step(1, 0);
      step(0, 0);
    end
  endtask
endmodule
